//--- hdl/ltpg_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Generator select: off, sequence, user, code.
// - Generator direction: transmit or receive path.
// - Receive generation: oscillator or recovered clock.
// - Transmit generation: oscillator, transmit clock, rail clock.
// - Generator invert flips sequence and user pattern.
// - Sequence length select: 20, 15, 11.
// - Detector direction: receive or transmit path.
// - Detector invert flips data before checking.
// - Detector select: three sequences or user pattern.
// - User pattern 24 bits, bit 23 first.
// - Transmit code length 5 to 8 bits.
// - Activate code length 5 to 8 bits.
// - Deactivate code length 5 to 8 bits.
// - Transmit code repeats back to back, bit 0 last.
// - Activate code matched with bit 0 last.
// - Deactivate code matched with bit 0 last.
// - Error request rise corrupts one sequence or user bit, self-clears.
// - Auto loopback after 5.1 s of code.
module ltpg_top #(
   parameter longint HOLD_CYCLES = ltpg_pkg::HOLD_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic [31:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic OSC_TICK,
   input wire logic RX_RECOVERED_TICK,
   input wire logic TX_CLOCK_TICK,
   input wire logic TX_RAIL_TICK,
   input wire logic RX_DATA,
   input wire logic TX_DATA,
   output logic TX_PATTERN_VALID,
   output logic RX_PATTERN_VALID,
   output logic PATTERN_BIT,
   output logic LOOPBACK_ACTIVE
);
   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0] gen_q, det_q, ulo_q, umid_q, uhi_q, len_q, ctx_q, cact_q, cdeact_q;
   logic err_req_q, auto_q;
   logic [1:0] line_mode_q;
   ltpg_pkg::ltpg_status_type st;
   wire [9:0] idx = PADDR[11:2];
   wire setup = PSEL && !PENABLE;
   // A write lands only at the edge where the master sees the answer.
   wire wr = PSEL && PENABLE && PREADY && PWRITE;
   wire hit = idx == ltpg_pkg::IDX_GEN_CTRL || idx == ltpg_pkg::IDX_DET_CTRL
      || idx == ltpg_pkg::IDX_USER_LOW || idx == ltpg_pkg::IDX_USER_MID
      || idx == ltpg_pkg::IDX_USER_HIGH || idx == ltpg_pkg::IDX_CODE_LEN
      || idx == ltpg_pkg::IDX_CODE_TX || idx == ltpg_pkg::IDX_CODE_ACT
      || idx == ltpg_pkg::IDX_CODE_DEACT || idx == ltpg_pkg::IDX_ERR_CTRL
      || idx == ltpg_pkg::IDX_LOOP_CTRL || idx == ltpg_pkg::IDX_STATUS
      || idx == ltpg_pkg::IDX_LINE_MODE;
   wire [23:0] user_pat = {uhi_q, umid_q, ulo_q};
   logic err_done;
   logic [7:0] rd_val;
   always_comb begin
      if (idx == ltpg_pkg::IDX_GEN_CTRL) rd_val = gen_q;
      else if (idx == ltpg_pkg::IDX_DET_CTRL) rd_val = det_q;
      else if (idx == ltpg_pkg::IDX_USER_LOW) rd_val = ulo_q;
      else if (idx == ltpg_pkg::IDX_USER_MID) rd_val = umid_q;
      else if (idx == ltpg_pkg::IDX_USER_HIGH) rd_val = uhi_q;
      else if (idx == ltpg_pkg::IDX_CODE_LEN) rd_val = len_q;
      else if (idx == ltpg_pkg::IDX_CODE_TX) rd_val = ctx_q;
      else if (idx == ltpg_pkg::IDX_CODE_ACT) rd_val = cact_q;
      else if (idx == ltpg_pkg::IDX_CODE_DEACT) rd_val = cdeact_q;
      else if (idx == ltpg_pkg::IDX_ERR_CTRL) rd_val = {2'h0, err_req_q, 5'h00};
      else if (idx == ltpg_pkg::IDX_LOOP_CTRL) rd_val = {4'h0, auto_q, 3'h0};
      else if (idx == ltpg_pkg::IDX_STATUS) rd_val = {4'h0, st};
      else if (idx == ltpg_pkg::IDX_LINE_MODE) rd_val = {6'h00, line_mode_q};
      else rd_val = 8'h00;
   end
   // Every access answers in its first access cycle: setup, then one access cycle.
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup && !hit;
         if (setup && !PWRITE) PRDATA <= {24'h0, rd_val};
      end
   end
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         gen_q <= ltpg_pkg::RST_GEN_CTRL;
         det_q <= ltpg_pkg::RST_DET_CTRL;
         ulo_q <= ltpg_pkg::RST_USER;
         umid_q <= ltpg_pkg::RST_USER;
         uhi_q <= ltpg_pkg::RST_USER;
         len_q <= ltpg_pkg::RST_CODE_LEN;
         ctx_q <= ltpg_pkg::RST_CODE_TX;
         cact_q <= ltpg_pkg::RST_CODE_ACT;
         cdeact_q <= ltpg_pkg::RST_CODE_DEACT;
         auto_q <= 1'b0;
         line_mode_q <= 2'b00;
      end else if (wr) begin
         if (idx == ltpg_pkg::IDX_GEN_CTRL) gen_q <= {1'b0, PWDATA[6:0]};
         else if (idx == ltpg_pkg::IDX_DET_CTRL) det_q <= {4'h0, PWDATA[3:0]};
         else if (idx == ltpg_pkg::IDX_USER_LOW) ulo_q <= PWDATA[7:0];
         else if (idx == ltpg_pkg::IDX_USER_MID) umid_q <= PWDATA[7:0];
         else if (idx == ltpg_pkg::IDX_USER_HIGH) uhi_q <= PWDATA[7:0];
         else if (idx == ltpg_pkg::IDX_CODE_LEN) len_q <= {2'h0, PWDATA[5:0]};
         else if (idx == ltpg_pkg::IDX_CODE_TX) ctx_q <= PWDATA[7:0];
         else if (idx == ltpg_pkg::IDX_CODE_ACT) cact_q <= PWDATA[7:0];
         else if (idx == ltpg_pkg::IDX_CODE_DEACT) cdeact_q <= PWDATA[7:0];
         else if (idx == ltpg_pkg::IDX_LOOP_CTRL) auto_q <= PWDATA[ltpg_pkg::AUTO_LOOP_BIT];
         else if (idx == ltpg_pkg::IDX_LINE_MODE) line_mode_q <= PWDATA[1:0];
      end
   end
   // ---------------------------------------------------------------
   // Error insertion request
   // ---------------------------------------------------------------
   wire err_wr = wr && idx == ltpg_pkg::IDX_ERR_CTRL;
   wire err_rise = err_wr && PWDATA[ltpg_pkg::ERROR_INSERT_REQUEST_BIT] && !err_req_q;
   logic err_pend_q;
   // A new rising write wins over the completion of an older one.
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         err_req_q <= 1'b0;
         err_pend_q <= 1'b0;
      end else if (err_rise) begin
         err_req_q <= 1'b1;
         err_pend_q <= 1'b1;
      end else if (err_wr && !PWDATA[ltpg_pkg::ERROR_INSERT_REQUEST_BIT]) begin
         err_req_q <= 1'b0;
         err_pend_q <= 1'b0;
      end else if (err_done) begin
         err_req_q <= 1'b0;
         err_pend_q <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // Generator
   // ---------------------------------------------------------------
   wire [1:0] gsel = gen_q[ltpg_pkg::GEN_SEL_LSB +: 2];
   wire gdir = gen_q[ltpg_pkg::GEN_DIR_BIT];
   wire gck = gen_q[ltpg_pkg::GEN_CLK_BIT];
   // Line mode 2'b10 is dual-rail RZ: the rail-derived clock stands in for the clock pin.
   wire tx_tick = line_mode_q == 2'b10 ? TX_RAIL_TICK : TX_CLOCK_TICK;
   wire gtick = !gck ? OSC_TICK : (gdir ? RX_RECOVERED_TICK : tx_tick);
   logic [19:0] glfsr_q;
   logic [4:0] gpos_q;
   logic [2:0] gcode_q;
   logic gbit;
   wire [1:0] glen = gen_q[1:0];
   logic gfb;
   always_comb begin
      if (glen == ltpg_pkg::SEQ_20) gfb = glfsr_q[19] ^ glfsr_q[16];
      else if (glen == ltpg_pkg::SEQ_15) gfb = glfsr_q[14] ^ glfsr_q[13];
      else gfb = glfsr_q[10] ^ glfsr_q[8];
   end
   // QRSS forces a one after fourteen zeros in the output.
   logic [3:0] zrun_q;
   wire qrss_bit = (glen == ltpg_pkg::SEQ_20 && zrun_q == 4'd14) ? 1'b1 : glfsr_q[19];
   wire seq_bit = glen == ltpg_pkg::SEQ_20 ? qrss_bit
      : (glen == ltpg_pkg::SEQ_15 ? glfsr_q[14] : glfsr_q[10]);
   wire [2:0] tx_top = 3'd4 + {1'b0, len_q[ltpg_pkg::TXLEN_LSB +: 2]};
   always_comb begin
      if (gsel == ltpg_pkg::GEN_PRBS) gbit = seq_bit ^ gen_q[ltpg_pkg::GEN_INV_BIT];
      else if (gsel == ltpg_pkg::GEN_USER) gbit = user_pat[gpos_q] ^ gen_q[ltpg_pkg::GEN_INV_BIT];
      else gbit = ctx_q[gcode_q];
   end
   wire gen_on = gsel != ltpg_pkg::GEN_OFF;
   wire ins_now = gen_on && gtick && err_pend_q && gsel != ltpg_pkg::GEN_CODE;
   assign err_done = ins_now;
   always_ff @(posedge REF_CLK) begin
      if (RESET || !gen_on) begin
         glfsr_q <= 20'hfffff;
         gpos_q <= 5'd23;
         gcode_q <= 3'd0;
         zrun_q <= 4'd0;
      end else if (gtick) begin
         glfsr_q <= {glfsr_q[18:0], gfb};
         zrun_q <= qrss_bit ? 4'd0 : zrun_q + 4'd1;
         gpos_q <= gpos_q == 5'd0 ? 5'd23 : gpos_q - 5'd1;
         gcode_q <= gcode_q == 3'd0 ? tx_top : gcode_q - 3'd1;
      end
   end
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         PATTERN_BIT <= 1'b0;
         TX_PATTERN_VALID <= 1'b0;
         RX_PATTERN_VALID <= 1'b0;
      end else begin
         PATTERN_BIT <= gbit ^ ins_now;
         TX_PATTERN_VALID <= gen_on && gtick && !gdir;
         RX_PATTERN_VALID <= gen_on && gtick && gdir;
      end
   end
   // ---------------------------------------------------------------
   // Detector
   // ---------------------------------------------------------------
   // Monitored path bits advance on that path's own clock tick.
   wire ddir = det_q[ltpg_pkg::DET_DIR_BIT];
   wire dtick = ddir ? tx_tick : RX_RECOVERED_TICK;
   wire raw = ddir ? TX_DATA : RX_DATA;
   wire dbit = raw ^ det_q[ltpg_pkg::DET_INV_BIT];
   logic [23:0] dsh_q;
   logic [7:0] csh_q;
   logic [4:0] dpos_q;
   wire [1:0] dsel = det_q[1:0];
   logic pred;
   always_comb begin
      if (dsel == 2'b00) pred = dsh_q[19] ^ dsh_q[16];
      else if (dsel == 2'b01) pred = dsh_q[14] ^ dsh_q[13];
      else if (dsel == 2'b10) pred = dsh_q[10] ^ dsh_q[8];
      else pred = user_pat[dpos_q];
   end
   // User pattern hunts its phase by slipping one bit on every mismatch.
   logic [5:0] sync_q;
   wire match = pred == dbit;
   // Code period match: shift register low bits hold the last bits, bit 0 newest.
   function automatic logic code_hit(input logic [7:0] sh, input logic [7:0] c,
                                     input logic [1:0] l);
      logic [7:0] m;
      m = 8'h1f;
      if (l == 2'b01) m = 8'h3f;
      else if (l == 2'b10) m = 8'h7f;
      else if (l == 2'b11) m = 8'hff;
      code_hit = ((sh ^ c) & m) == 8'h00;
   endfunction
   wire [7:0] csh_d = {csh_q[6:0], dbit};
   wire act_hit = code_hit(csh_d, cact_q, len_q[ltpg_pkg::ACTLEN_LSB +: 2]);
   wire deact_hit = code_hit(csh_d, cdeact_q, len_q[ltpg_pkg::DEACTLEN_LSB +: 2]);
   // A code counts one hit per period; a whole period without a hit starts over.
   logic [5:0] act_q, deact_q;
   logic [3:0] act_gap_q, deact_gap_q;
   wire [3:0] act_len = 4'd5 + {2'b00, len_q[ltpg_pkg::ACTLEN_LSB +: 2]};
   wire [3:0] deact_len = 4'd5 + {2'b00, len_q[ltpg_pkg::DEACTLEN_LSB +: 2]};
   wire act_lost = act_gap_q >= act_len - 4'd1;
   wire deact_lost = deact_gap_q >= deact_len - 4'd1;
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         dsh_q <= 24'h0;
         csh_q <= 8'h0;
         dpos_q <= 5'd23;
         sync_q <= 6'd0;
         act_q <= 6'd0;
         deact_q <= 6'd0;
         act_gap_q <= 4'd0;
         deact_gap_q <= 4'd0;
      end else if (dtick) begin
         dsh_q <= {dsh_q[22:0], dbit};
         csh_q <= csh_d;
         if (match) dpos_q <= dpos_q == 5'd0 ? 5'd23 : dpos_q - 5'd1;
         sync_q <= !match ? 6'd0 : (sync_q == ltpg_pkg::SYNC_COUNT ? sync_q : sync_q + 6'd1);
         act_gap_q <= act_hit ? 4'd0 : (act_lost ? act_gap_q : act_gap_q + 4'd1);
         deact_gap_q <= deact_hit ? 4'd0 : (deact_lost ? deact_gap_q : deact_gap_q + 4'd1);
         act_q <= act_hit ? (act_q == ltpg_pkg::CODE_COUNT ? act_q : act_q + 6'd1)
            : (act_lost ? 6'd0 : act_q);
         deact_q <= deact_hit ? (deact_q == ltpg_pkg::CODE_COUNT ? deact_q : deact_q + 6'd1)
            : (deact_lost ? 6'd0 : deact_q);
      end
   end
   assign st = {LOOPBACK_ACTIVE, deact_q == ltpg_pkg::CODE_COUNT,
      act_q == ltpg_pkg::CODE_COUNT, sync_q == ltpg_pkg::SYNC_COUNT};
   // ---------------------------------------------------------------
   // Automatic loopback
   // ---------------------------------------------------------------
   logic [31:0] hold_q;
   wire want = LOOPBACK_ACTIVE ? st.deact_seen : st.act_seen;
   always_ff @(posedge REF_CLK) begin
      if (RESET || !auto_q) begin
         hold_q <= 32'd0;
         LOOPBACK_ACTIVE <= 1'b0;
      end else if (!want) begin
         hold_q <= 32'd0;
      end else if (hold_q >= 32'(HOLD_CYCLES)) begin
         LOOPBACK_ACTIVE <= !LOOPBACK_ACTIVE;
         hold_q <= 32'd0;
      end else begin
         hold_q <= hold_q + 32'd1;
      end
   end
endmodule

//--- include/ltpg_pkg.sv
package ltpg_pkg;
   // Register indices as printed; byte address is four times the index.
   localparam logic [9:0] IDX_GEN_CTRL = 10'h010;
   localparam logic [9:0] IDX_DET_CTRL = 10'h011;
   localparam logic [9:0] IDX_USER_LOW = 10'h012;
   localparam logic [9:0] IDX_USER_MID = 10'h013;
   localparam logic [9:0] IDX_USER_HIGH = 10'h014;
   localparam logic [9:0] IDX_CODE_LEN = 10'h015;
   localparam logic [9:0] IDX_CODE_TX = 10'h016;
   localparam logic [9:0] IDX_CODE_ACT = 10'h017;
   localparam logic [9:0] IDX_CODE_DEACT = 10'h018;
   localparam logic [9:0] IDX_ERR_CTRL = 10'h01e;
   localparam logic [9:0] IDX_LOOP_CTRL = 10'h01f;
   localparam logic [9:0] IDX_STATUS = 10'h020;
   localparam logic [9:0] IDX_LINE_MODE = 10'h021;

   localparam logic [7:0] RST_GEN_CTRL = 8'h00;
   localparam logic [7:0] RST_DET_CTRL = 8'h03;
   localparam logic [7:0] RST_USER = 8'h55;
   localparam logic [7:0] RST_CODE_LEN = 8'h01;
   localparam logic [7:0] RST_CODE_TX = 8'h01;
   localparam logic [7:0] RST_CODE_ACT = 8'h01;
   localparam logic [7:0] RST_CODE_DEACT = 8'h09;

   // Field positions.
   localparam int GEN_CLK_BIT = 6;
   localparam int GEN_SEL_LSB = 4;
   localparam int GEN_DIR_BIT = 3;
   localparam int GEN_INV_BIT = 2;
   localparam int DET_DIR_BIT = 3;
   localparam int DET_INV_BIT = 2;
   localparam int TXLEN_LSB = 4;
   localparam int ACTLEN_LSB = 2;
   localparam int DEACTLEN_LSB = 0;
   localparam int ERROR_INSERT_REQUEST_BIT = 5;
   localparam int AUTO_LOOP_BIT = 3;

   localparam logic [1:0] GEN_OFF = 2'b00;
   localparam logic [1:0] GEN_PRBS = 2'b01;
   localparam logic [1:0] GEN_USER = 2'b10;
   localparam logic [1:0] GEN_CODE = 2'b11;
   localparam logic [1:0] SEQ_20 = 2'b00;
   localparam logic [1:0] SEQ_15 = 2'b01;
   localparam logic [1:0] DET_USER = 2'b11;

   // Lock thresholds for sequence sync and code detection.
   localparam logic [5:0] SYNC_COUNT = 6'd48;
   localparam logic [5:0] CODE_COUNT = 6'd48;
   localparam real HOLD_TIME_S = 5.1;
   localparam real CLK_HZ = 25.0e6;
   localparam longint HOLD_CYCLES = longint'(HOLD_TIME_S * CLK_HZ) + 1;

   typedef struct packed {
      logic auto_loop;
      logic deact_seen;
      logic act_seen;
      logic pattern_sync;
   } ltpg_status_type;
endpackage

//--- tb/ltpg_path_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Far side: bit clock enables and a loop of the generated stream.
// ---------------------------------------------------------------
module ltpg_path_model (
   input wire logic clk,
   input wire logic [3:0] tick_en,
   input wire logic flip,
   input wire logic tx_valid,
   input wire logic rx_valid,
   input wire logic pattern_bit,
   output logic [3:0] tick,
   output logic rx_data,
   output logic tx_data
);
   logic [1:0] phase_q = 2'h0;
   logic bit_q = 1'b0;
   logic to_tx_q = 1'b1;
   logic junk_q = 1'b0;
   always_ff @(posedge clk) begin
      phase_q <= phase_q + 2'h1;
      junk_q <= ~junk_q;
      if (tx_valid || rx_valid) begin
         bit_q <= pattern_bit ^ flip;
         to_tx_q <= tx_valid;
      end
   end
   // The path that does not carry the loop toggles, so a stale copy cannot fake a match.
   assign tick = (phase_q == 2'h0) ? tick_en : 4'h0;
   assign tx_data = to_tx_q ? bit_q : junk_q;
   assign rx_data = to_tx_q ? junk_q : bit_q;
endmodule

//--- tb/ltpg_properties.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Port checker.
// ---------------------------------------------------------------
module ltpg_properties #(
   parameter longint HOLD_CYCLES = 100
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic OSC_TICK,
   input wire logic RX_RECOVERED_TICK,
   input wire logic TX_CLOCK_TICK,
   input wire logic TX_RAIL_TICK,
   input wire logic TX_PATTERN_VALID,
   input wire logic RX_PATTERN_VALID,
   input wire logic LOOPBACK_ACTIVE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   wire logic any_tx = OSC_TICK || TX_CLOCK_TICK || TX_RAIL_TICK;
   wire logic any_rx = OSC_TICK || RX_RECOVERED_TICK;
   logic loop_q;
   longint held_q;
   // Cycles since the loopback level last moved; a move needs a full hold before it.
   always_ff @(posedge REF_CLK) begin
      loop_q <= LOOPBACK_ACTIVE;
      held_q <= (RESET || LOOPBACK_ACTIVE != loop_q) ? 64'sd0 : held_q + 64'sd1;
   end
   sequence setup_s;
      PSEL && !PENABLE;
   endsequence
   sequence answer_s;
      PSEL && PENABLE && PREADY;
   endsequence
   chk_setup_answer: assert property (setup_s |=> answer_s)
      else $error("no ready after setup");
   chk_ready_single: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   chk_error_zero: assert property (PSLVERR && !PWRITE |-> PREADY && PRDATA == 32'h0)
      else $error("refused read not zero");
   chk_data_byte: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
      else $error("read data above byte");
   chk_one_path: assert property (!(TX_PATTERN_VALID && RX_PATTERN_VALID))
      else $error("pattern on both paths");
   chk_tx_tick: assert property (TX_PATTERN_VALID |-> $past(any_tx))
      else $error("transmit bit without tick");
   chk_rx_tick: assert property (RX_PATTERN_VALID |-> $past(any_rx))
      else $error("receive bit without tick");
   chk_loop_hold: assert property (LOOPBACK_ACTIVE != loop_q |-> held_q >= HOLD_CYCLES)
      else $error("loopback moved before hold");
endmodule

bind ltpg_top ltpg_properties #(.HOLD_CYCLES(HOLD_CYCLES)) i_props (
   .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .OSC_TICK(OSC_TICK),
   .RX_RECOVERED_TICK(RX_RECOVERED_TICK), .TX_CLOCK_TICK(TX_CLOCK_TICK),
   .TX_RAIL_TICK(TX_RAIL_TICK), .TX_PATTERN_VALID(TX_PATTERN_VALID),
   .RX_PATTERN_VALID(RX_PATTERN_VALID), .LOOPBACK_ACTIVE(LOOPBACK_ACTIVE));

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic flip = 1'b0;
   logic [3:0] mask = 4'hf;
   logic [31:0] prdata;
   logic [3:0] tick;
   logic pready, pslverr, rxd, txd, txv, rxv, pbit, loop, err_q;
   int checks = 0;
   int fail_count = 0;
   initial forever #20 clk = ~clk;
   ltpg_top #(.HOLD_CYCLES(100)) i_dut (
      .REF_CLK(clk), .RESET(rst), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .OSC_TICK(tick[0]), .RX_RECOVERED_TICK(tick[1]),
      .TX_CLOCK_TICK(tick[2]), .TX_RAIL_TICK(tick[3]), .RX_DATA(rxd), .TX_DATA(txd),
      .TX_PATTERN_VALID(txv), .RX_PATTERN_VALID(rxv), .PATTERN_BIT(pbit),
      .LOOPBACK_ACTIVE(loop));
   ltpg_path_model i_path (.clk(clk), .tick_en(mask), .flip(flip), .tx_valid(txv),
      .rx_valid(rxv), .pattern_bit(pbit), .tick(tick), .rx_data(rxd), .tx_data(txd));
   // ---------------------------------------------------------------
   // Bus cycles and comparisons.
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic [9:0] i, input logic w, input logic [7:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      paddr <= {20'h0, i, 2'b00};
      pwrite <= w;
      pwdata <= {24'h0, d};
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      logic [31:0] r;
      apb(i, 1'b1, d, r);
   endtask
   task automatic rd_chk(input logic [9:0] i, input logic [31:0] e);
      logic [31:0] r;
      apb(i, 1'b0, 8'h0, r);
      chk(r, e);
   endtask
   // A flag expected clear is only read after the stream had time to set it wrongly.
   task automatic poll(input logic [9:0] i, input logic [7:0] m, input logic [7:0] e);
      logic [31:0] r;
      int k;
      k = 0;
      if (e == 8'h0) repeat (400) @(posedge clk);
      do begin
         apb(i, 1'b0, 8'h0, r);
         k++;
      end while ((r[7:0] & m) !== e && k < 600);
      chk(r & {24'h0, m}, {24'h0, e});
   endtask
   task automatic grab(input int n, output logic [63:0] w);
      int k;
      w = 64'h0;
      k = 0;
      while (n > 0 && k < 2000) begin
         @(posedge clk);
         k++;
         if (txv === 1'b1 || rxv === 1'b1) begin
            w = {w[62:0], pbit};
            n--;
         end
      end
   endtask
   function automatic logic rep(logic [63:0] w, logic [31:0] p, int l);
      logic [31:0] m;
      logic hit;
      m = (32'h1 << l) - 32'h1;
      hit = 1'b0;
      for (int r = 0; r < l; r++) hit |= ((((p << r) | (p >> (l - r))) & m) == (w[31:0] & m));
      return hit && ((w[31:0] & m) == (32'(w >> l) & m));
   endfunction
   task automatic gen_chk(input logic [31:0] p, input int l);
      logic [63:0] w;
      grab(4, w);
      grab(2 * l, w);
      chk({31'h0, rep(w, p, l)}, 32'h1);
   endtask
   initial begin
      logic [31:0] r;
      logic [7:0] rv [9];
      logic [20:0] ck [6];
      int n;
      rv = '{8'h00, 8'h03, 8'h55, 8'h55, 8'h55, 8'h01, 8'h01, 8'h01, 8'h09};
      ck = '{{8'h68, 8'h00, 4'h1, 1'b0}, {8'h68, 8'h00, 4'h2, 1'b1}, {8'h60, 8'h02, 4'h4, 1'b0},
             {8'h60, 8'h02, 4'h8, 1'b1}, {8'h20, 8'h00, 4'h1, 1'b1}, {8'h20, 8'h00, 4'h4, 1'b0}};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rv[i]) rd_chk(10'h010 + 10'(i), {24'h0, rv[i]});
      apb(10'h3ff, 1'b0, 8'h0, r);
      chk(r, 32'h0);
      chk({31'h0, err_q}, 32'h1);
      wr(10'h020, 8'hff);
      rd_chk(10'h020, 32'h0);
      wr(10'h012, 8'hf0);
      wr(10'h013, 8'ha5);
      wr(10'h014, 8'hc3);
      rd_chk(10'h014, 32'hc3);
      foreach (ck[i]) begin
         mask <= ck[i][4:1];
         wr(10'h021, ck[i][12:5]);
         wr(10'h010, ck[i][20:13]);
         n = 0;
         repeat (40) begin
            @(posedge clk);
            n += ((ck[i][16] ? rxv : txv) === 1'b1);
         end
         chk({31'h0, n != 0}, {31'h0, ck[i][0]});
      end
      mask <= 4'hf;
      wr(10'h021, 8'h00);
      wr(10'h010, 8'h20);
      gen_chk(32'hc3a5f0, 24);
      wr(10'h010, 8'h24);
      gen_chk(32'h3c5a0f, 24);
      wr(10'h010, 8'h20);
      wr(10'h011, 8'h0b);
      poll(10'h020, 8'h01, 8'h01);
      flip <= 1'b1;
      poll(10'h020, 8'h01, 8'h00);
      wr(10'h011, 8'h0f);
      poll(10'h020, 8'h01, 8'h01);
      flip <= 1'b0;
      wr(10'h011, 8'h0b);
      wr(10'h010, 8'h28);
      poll(10'h020, 8'h01, 8'h00);
      wr(10'h011, 8'h03);
      poll(10'h020, 8'h01, 8'h01);
      wr(10'h01e, 8'h20);
      poll(10'h01e, 8'h20, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(10'h011, (i == 3) ? 8'h02 : 8'(i));
         wr(10'h010, 8'h18 | 8'(i));
         poll(10'h020, 8'h01, 8'h01);
      end
      wr(10'h011, 8'h01);
      poll(10'h020, 8'h01, 8'h00);
      wr(10'h016, 8'h17);
      for (int i = 0; i < 4; i++) begin
         wr(10'h015, {2'b00, 2'(i), 4'h1});
         wr(10'h010, 8'h34);
         gen_chk(32'h17, i + 5);
      end
      wr(10'h015, 8'h01);
      wr(10'h016, 8'h01);
      wr(10'h01f, 8'h08);
      wr(10'h010, 8'h38);
      poll(10'h020, 8'h06, 8'h02);
      n = 0;
      while (loop !== 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, loop}, 32'h1);
      wr(10'h015, 8'h11);
      wr(10'h016, 8'h09);
      poll(10'h020, 8'h06, 8'h04);
      n = 0;
      while (loop !== 1'b0 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, loop}, 32'h0);
      stop_test();
   end
   initial begin
      repeat (80000) @(posedge clk);
      fail_count++;
      stop_test();
   end
endmodule
